// >>> core/t16pg_defines.svh
// constants of the 16-bit timer with pulse generator, one-shot and capture
// assumes: included by bare name from package and modules; definitions only
`ifndef T16PG_DEFINES_SVH
`define T16PG_DEFINES_SVH

// apb byte offsets, one aligned word each
`define T16PG_OFF_MODE      8'h00
`define T16PG_OFF_CCCTL     8'h04
`define T16PG_OFF_OUTCTL    8'h08
`define T16PG_OFF_PRESCALE  8'h0C
`define T16PG_OFF_COUNTER   8'h10
`define T16PG_OFF_CC_FIRST  8'h14
`define T16PG_OFF_CC_SECOND 8'h18

// mode_control_reg fields
`define T16PG_MC_OVF        0
`define T16PG_MC_MODE_LO    2
`define T16PG_MC_MODE_HI    3
// capture_compare_control_reg fields
`define T16PG_CC_FIRST_CAP  0
`define T16PG_CC_FIRST_TRB  1
`define T16PG_CC_SECOND_CAP 2
// output_control_reg fields
`define T16PG_OC_OUT_EN     0
`define T16PG_OC_TOGGLE_EN  1
`define T16PG_OC_OS_EN      5
`define T16PG_OC_OS_TRIG    6
// prescaler_mode_reg fields
`define T16PG_PM_DIV_LO     0
`define T16PG_PM_DIV_HI     2
`define T16PG_PM_EA_LO      4
`define T16PG_PM_EA_HI      5
`define T16PG_PM_EB_LO      6
`define T16PG_PM_EB_HI      7

// encodings
`define T16PG_MODE_STOP     2'h0
`define T16PG_MODE_FREE     2'h1
`define T16PG_MODE_CLR_EDGE 2'h2
`define T16PG_MODE_CLR_MAT  2'h3
`define T16PG_EDGE_FALL     2'h0
`define T16PG_EDGE_RISE     2'h1
`define T16PG_EDGE_NONE     2'h2
`define T16PG_EDGE_BOTH     2'h3
`define T16PG_OS_IDLE       3'h1
`define T16PG_OS_WAIT       3'h2
`define T16PG_OS_PULSE      3'h4

// values and widths
`define T16PG_CNT_ZERO      16'h0000
`define T16PG_CNT_MAX       16'hFFFF
`define T16PG_CNT_ONE       16'h0001
`define T16PG_DIV_W         3
`define T16PG_PRE_W         7
`define T16PG_PRE_ZERO      7'h00
`define T16PG_PRE_ONE       7'h01
`define T16PG_WORD_ZERO     32'h00000000

`endif

// >>> core/t16pg_pkg.sv
// types shared by the timer modules
// assumes: t16pg_defines.svh on the include path
`include "t16pg_defines.svh"

package t16pg_pkg;

    typedef enum logic [1:0] {
        T16PG_MODE_STOP     = `T16PG_MODE_STOP,
        T16PG_MODE_FREE     = `T16PG_MODE_FREE,
        T16PG_MODE_CLR_EDGE = `T16PG_MODE_CLR_EDGE,
        T16PG_MODE_CLR_MAT  = `T16PG_MODE_CLR_MAT
    } t16pg_mode_type;

    typedef enum logic [1:0] {
        T16PG_EDGE_FALL = `T16PG_EDGE_FALL,
        T16PG_EDGE_RISE = `T16PG_EDGE_RISE,
        T16PG_EDGE_NONE = `T16PG_EDGE_NONE,
        T16PG_EDGE_BOTH = `T16PG_EDGE_BOTH
    } t16pg_edge_type;

    typedef enum logic [2:0] {
        T16PG_OS_IDLE  = `T16PG_OS_IDLE,
        T16PG_OS_WAIT  = `T16PG_OS_WAIT,
        T16PG_OS_PULSE = `T16PG_OS_PULSE
    } t16pg_os_type;

    typedef struct packed {
        logic prev;
        logic seen;
    } t16pg_edge_state_type;

    typedef struct packed {
        logic [`T16PG_PRE_W-1:0] cnt;
    } t16pg_pre_state_type;

    typedef struct packed {
        logic [15:0]              cnt;
        logic [15:0]              cc_first;
        logic [15:0]              cc_second;
        t16pg_mode_type           mode;
        logic                     ovf;
        logic                     first_cap;
        logic                     first_trig_b;
        logic                     second_cap;
        logic                     out_en;
        logic                     toggle_en;
        logic                     os_en;
        logic [`T16PG_DIV_W-1:0]  div_sel;
        t16pg_edge_type           edge_a;
        t16pg_edge_type           edge_b;
        t16pg_os_type             os_state;
        logic                     out_level;
        logic                     out_pin;
        logic                     pend_clr;
        logic                     irq_first;
        logic                     irq_second;
        logic [31:0]              prdata;
    } t16pg_state_type;

endpackage : t16pg_pkg

// >>> core/t16pg_edge_det.sv
// valid-edge detector for one trigger input
// assumes: input synchronous to clk; first sample after reset is never an edge
`include "t16pg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module t16pg_edge_det (
    input  wire logic                  clk_in,    // system clock
    input  wire logic                  rst_b_in,  // synchronised reset, low active
    input  wire logic                  level_in,  // trigger input level
    input  wire t16pg_pkg::t16pg_edge_type sel_in, // which edge is valid
    output logic                       pulse_out  // one-cycle valid edge
);
    import t16pg_pkg::*;

    t16pg_edge_state_type s;
    t16pg_edge_state_type next_s;

    always_comb begin
        next_s      = s;
        next_s.prev = level_in;
        next_s.seen = 1'b1;
    end

    always_comb begin
        pulse_out = 1'b0;
        if (s.seen) begin
            case (sel_in)
                T16PG_EDGE_FALL: pulse_out = s.prev & ~level_in;
                T16PG_EDGE_RISE: pulse_out = ~s.prev & level_in;
                T16PG_EDGE_BOTH: pulse_out = s.prev ^ level_in;
                default:         pulse_out = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule : t16pg_edge_det
`default_nettype wire

// >>> core/t16pg_prescaler.sv
// count clock divider: one-cycle tick every 2**div_sel system clocks
// assumes: run_in low holds the divider at zero so each start is aligned
`include "t16pg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module t16pg_prescaler (
    input  wire logic                    clk_in,    // system clock
    input  wire logic                    rst_b_in,  // synchronised reset, low active
    input  wire logic                    run_in,    // counter running
    input  wire logic [`T16PG_DIV_W-1:0] div_in,    // divide exponent
    output logic                         tick_out   // count clock enable
);
    import t16pg_pkg::*;

    t16pg_pre_state_type s;
    t16pg_pre_state_type next_s;
    logic [`T16PG_PRE_W-1:0] mask;

    always_comb begin
        mask     = (`T16PG_PRE_ONE << div_in) - `T16PG_PRE_ONE;
        tick_out = run_in && ((s.cnt & mask) == mask);
        next_s   = s;
        if (!run_in || tick_out) begin
            next_s.cnt = `T16PG_PRE_ZERO;
        end else begin
            next_s.cnt = s.cnt + `T16PG_PRE_ONE;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule : t16pg_prescaler
`default_nettype wire

// >>> core/t16pg_top.sv
// 16-bit timer/event counter with two capture/compare registers, apb slave
// assumes: apb master per amba, trigger inputs synchronous to clk_sys_in
//
// Behaviour
// - first register captures on selected trigger A/B
// - second register captures on trigger A only
// - free-run compare matches raise irqs, no clear
// - mode 11 drives repeating pulse train
// - period first+1, duty (second+1)/(first+1)
// - pulse mode: first match clears, second doesn't
// - one-shot needs mode 01/10 and enable
// - soft bit or A edge restarts, one pulse
// - one-shot matches raise irq and toggle output
// - pulse after first+1, lasts second minus first
// - two-input width: A to second, B to first
// - overflow flag sticky until software writes zero
// - counter wraps at maximum, sets overflow
`include "t16pg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module t16pg_top (
    input  wire logic        clk_sys_in,          // 100 MHz system clock
    input  wire logic        rst_b_in,            // async reset, low active
    input  wire logic        psel_in,             // apb select
    input  wire logic        penable_in,          // apb access phase
    input  wire logic        pwrite_in,           // apb write
    input  wire logic [7:0]  paddr_in,            // apb byte address
    input  wire logic [31:0] pwdata_in,           // apb write data
    output logic [31:0]      prdata_out,          // apb read data
    output logic             pready_out,          // apb ready
    output logic             pslverr_out,         // apb error, unmapped
    input  wire logic        trigger_input_a_in,  // trigger input a
    input  wire logic        trigger_input_b_in,  // trigger input b
    output logic             timer_output_pin_out, // timer output
    output logic             first_match_irq_out, // first register event
    output logic             second_match_irq_out // second register event
);
    import t16pg_pkg::*;

    logic            rst_meta_b;
    logic            rst_sync_b;
    t16pg_state_type s;
    t16pg_state_type next_s;
    logic            tick;
    logic            edge_a;
    logic            edge_b;
    logic            wr_en;
    logic            os_ok;
    logic            soft_trig;
    logic            first_trig;
    logic            m_first;
    logic            m_second;

    // release is synchronised, assertion stays asynchronous
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    t16pg_prescaler u_pre (
        .clk_in   (clk_sys_in),
        .rst_b_in (rst_sync_b),
        .run_in   (s.mode != T16PG_MODE_STOP),
        .div_in   (s.div_sel),
        .tick_out (tick)
    );

    t16pg_edge_det u_edge_a (
        .clk_in    (clk_sys_in),
        .rst_b_in  (rst_sync_b),
        .level_in  (trigger_input_a_in),
        .sel_in    (s.edge_a),
        .pulse_out (edge_a)
    );

    t16pg_edge_det u_edge_b (
        .clk_in    (clk_sys_in),
        .rst_b_in  (rst_sync_b),
        .level_in  (trigger_input_b_in),
        .sel_in    (s.edge_b),
        .pulse_out (edge_b)
    );

    // a register in capture use never compares
    function automatic logic cmp_hit(input logic [15:0] cnt, input logic [15:0] val,
                                     input logic cap);
        cmp_hit = !cap && (cnt == val);
    endfunction : cmp_hit

    function automatic logic is_mapped(input logic [7:0] addr);
        case (addr)
            `T16PG_OFF_MODE, `T16PG_OFF_CCCTL, `T16PG_OFF_OUTCTL, `T16PG_OFF_PRESCALE,
            `T16PG_OFF_COUNTER, `T16PG_OFF_CC_FIRST, `T16PG_OFF_CC_SECOND: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    function automatic logic [31:0] read_mux(input logic [7:0] addr,
                                             input t16pg_state_type st);
        logic [31:0] d;
        d = `T16PG_WORD_ZERO;
        case (addr)
            `T16PG_OFF_MODE: begin
                d[`T16PG_MC_MODE_HI:`T16PG_MC_MODE_LO] = st.mode;
                d[`T16PG_MC_OVF]                       = st.ovf;
            end
            `T16PG_OFF_CCCTL: begin
                d[`T16PG_CC_FIRST_CAP]  = st.first_cap;
                d[`T16PG_CC_FIRST_TRB]  = st.first_trig_b;
                d[`T16PG_CC_SECOND_CAP] = st.second_cap;
            end
            `T16PG_OFF_OUTCTL: begin
                d[`T16PG_OC_OUT_EN]    = st.out_en;
                d[`T16PG_OC_TOGGLE_EN] = st.toggle_en;
                d[`T16PG_OC_OS_EN]     = st.os_en;
            end
            `T16PG_OFF_PRESCALE: begin
                d[`T16PG_PM_DIV_HI:`T16PG_PM_DIV_LO] = st.div_sel;
                d[`T16PG_PM_EA_HI:`T16PG_PM_EA_LO]   = st.edge_a;
                d[`T16PG_PM_EB_HI:`T16PG_PM_EB_LO]   = st.edge_b;
            end
            `T16PG_OFF_COUNTER:   d[15:0] = st.cnt;
            `T16PG_OFF_CC_FIRST:  d[15:0] = st.cc_first;
            `T16PG_OFF_CC_SECOND: d[15:0] = st.cc_second;
            default:              d = `T16PG_WORD_ZERO;
        endcase
        read_mux = d;
    endfunction : read_mux

    always_comb begin
        wr_en     = psel_in && penable_in && pwrite_in;
        os_ok     = s.os_en && ((s.mode == T16PG_MODE_FREE) ||
                                (s.mode == T16PG_MODE_CLR_EDGE));
        soft_trig = wr_en && (paddr_in == `T16PG_OFF_OUTCTL) &&
                    pwdata_in[`T16PG_OC_OS_TRIG];
        first_trig = s.first_trig_b ? edge_b : edge_a;
        m_first   = cmp_hit(s.cnt, s.cc_first, s.first_cap);
        m_second  = cmp_hit(s.cnt, s.cc_second, s.second_cap);

        next_s            = s;
        next_s.irq_first  = 1'b0;
        next_s.irq_second = 1'b0;

        // software writes first, so hardware updates below win the same cycle
        if (wr_en) begin
            case (paddr_in)
                `T16PG_OFF_MODE: begin
                    next_s.mode = t16pg_mode_type'(pwdata_in[`T16PG_MC_MODE_HI:`T16PG_MC_MODE_LO]);
                    next_s.ovf  = s.ovf & pwdata_in[`T16PG_MC_OVF];
                end
                `T16PG_OFF_CCCTL: begin
                    next_s.first_cap    = pwdata_in[`T16PG_CC_FIRST_CAP];
                    next_s.first_trig_b = pwdata_in[`T16PG_CC_FIRST_TRB];
                    next_s.second_cap   = pwdata_in[`T16PG_CC_SECOND_CAP];
                end
                `T16PG_OFF_OUTCTL: begin
                    next_s.out_en    = pwdata_in[`T16PG_OC_OUT_EN];
                    next_s.toggle_en = pwdata_in[`T16PG_OC_TOGGLE_EN];
                    next_s.os_en     = pwdata_in[`T16PG_OC_OS_EN];
                end
                `T16PG_OFF_PRESCALE: begin
                    next_s.div_sel = pwdata_in[`T16PG_PM_DIV_HI:`T16PG_PM_DIV_LO];
                    next_s.edge_a  = t16pg_edge_type'(pwdata_in[`T16PG_PM_EA_HI:`T16PG_PM_EA_LO]);
                    next_s.edge_b  = t16pg_edge_type'(pwdata_in[`T16PG_PM_EB_HI:`T16PG_PM_EB_LO]);
                end
                `T16PG_OFF_CC_FIRST:  next_s.cc_first  = pwdata_in[15:0];
                `T16PG_OFF_CC_SECOND: next_s.cc_second = pwdata_in[15:0];
                default: next_s.cc_first = s.cc_first;
            endcase
        end

        // restart requests wait for the next count clock so timing is tick-exact
        if ((os_ok && (soft_trig || edge_a)) ||
            (s.mode == T16PG_MODE_CLR_EDGE && edge_a)) begin
            next_s.pend_clr = 1'b1;
        end

        // captures act on the system clock, a capture beats a same-cycle write
        if (s.first_cap && first_trig && s.mode != T16PG_MODE_STOP) begin
            next_s.cc_first  = s.cnt;
            next_s.irq_first = 1'b1;
        end
        if (s.second_cap && edge_a && s.mode != T16PG_MODE_STOP) begin
            next_s.cc_second  = s.cnt;
            next_s.irq_second = 1'b1;
        end

        if (s.mode == T16PG_MODE_STOP) begin
            next_s.cnt       = `T16PG_CNT_ZERO;
            next_s.pend_clr  = 1'b0;
            next_s.os_state  = T16PG_OS_IDLE;
            next_s.out_level = 1'b0;
        end else if (tick) begin
            if (m_first) begin
                next_s.irq_first = 1'b1;
            end
            if (m_second) begin
                next_s.irq_second = 1'b1;
            end

            if (s.pend_clr) begin
                next_s.cnt      = `T16PG_CNT_ZERO;
                next_s.pend_clr = 1'b0;
            end else if (s.mode == T16PG_MODE_CLR_MAT && m_first) begin
                next_s.cnt = `T16PG_CNT_ZERO;
            end else if (s.cnt == `T16PG_CNT_MAX) begin
                next_s.cnt = `T16PG_CNT_ZERO;
                next_s.ovf = 1'b1;
            end else begin
                next_s.cnt = s.cnt + `T16PG_CNT_ONE;
            end

            if (s.mode == T16PG_MODE_CLR_MAT) begin
                // high for counts 0..second, period first+1 counts
                next_s.out_level = (next_s.cnt <= s.cc_second);
            end else if (os_ok) begin
                if (s.pend_clr) begin
                    next_s.os_state  = T16PG_OS_WAIT;
                    next_s.out_level = 1'b0;
                end else begin
                    case (s.os_state)
                        T16PG_OS_WAIT: begin
                            if (m_first) begin
                                next_s.os_state  = T16PG_OS_PULSE;
                                next_s.out_level = ~s.out_level;
                            end
                        end
                        T16PG_OS_PULSE: begin
                            if (m_second) begin
                                next_s.os_state  = T16PG_OS_IDLE;
                                next_s.out_level = ~s.out_level;
                            end
                        end
                        T16PG_OS_IDLE: begin
                            next_s.out_level = 1'b0;
                        end
                        default: begin
                            next_s.os_state  = T16PG_OS_IDLE;
                            next_s.out_level = 1'b0;
                        end
                    endcase
                end
            end else if (s.toggle_en && (m_first || m_second)) begin
                next_s.out_level = ~s.out_level;
            end
        end

        next_s.out_pin = next_s.out_level & next_s.out_en;

        // read data is latched in the setup phase and stands through access
        if (psel_in && !penable_in) begin
            next_s.prdata = read_mux(paddr_in, s);
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            s          <= '0;
            s.os_state <= T16PG_OS_IDLE;
            s.edge_a   <= T16PG_EDGE_NONE;
            s.edge_b   <= T16PG_EDGE_NONE;
        end else begin
            s <= next_s;
        end
    end

    assign prdata_out           = s.prdata;
    assign pready_out           = 1'b1;
    assign pslverr_out          = psel_in && penable_in && !is_mapped(paddr_in);
    assign timer_output_pin_out = s.out_pin;
    assign first_match_irq_out  = s.irq_first;
    assign second_match_irq_out = s.irq_second;

endmodule : t16pg_top
`default_nettype wire

// >>> verification/t16pg_assertions.sv
// timer checker: apb and pin timing at top ports
// assumes: bound to t16pg_top; legal compare values
`timescale 1ns/1ps
`default_nettype none

module t16pg_chk (
    input  wire logic        clk_sys_in,           // system clock
    input  wire logic        rst_b_in,             // reset, low active
    input  wire logic        psel_in,              // apb select
    input  wire logic        penable_in,           // apb access
    input  wire logic        pwrite_in,            // apb write
    input  wire logic [7:0]  paddr_in,             // apb address
    input  wire logic [31:0] pwdata_in,            // apb write data
    input  wire logic        pready_out,           // apb ready
    input  wire logic        pslverr_out,          // apb error
    input  wire logic        trigger_input_a_in,   // trigger a
    input  wire logic        trigger_input_b_in,   // trigger b
    input  wire logic        timer_output_pin_out, // timer output
    input  wire logic        first_match_irq_out,  // first event
    input  wire logic        second_match_irq_out  // second event
);
    logic [1:0]  m;
    logic [2:0]  cc;
    logic        os;
    logic [7:0]  pm;
    logic [15:0] f;
    logic [15:0] s;
    logic        arm;
    logic [23:0] g1;
    logic [23:0] g2;
    wire         wr = psel_in && penable_in && pwrite_in && pready_out;

    // settings shadow; writes disarm gap checks
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            {m, cc, os, pm, f, s} <= {2'h0, 3'h0, 1'h0, 8'hA0, 32'h0};
            {arm, g1, g2} <= '0;
        end else begin
            g1 <= first_match_irq_out ? 24'h1 : g1 + 24'h1;
            g2 <= second_match_irq_out ? 24'h1 : g2 + 24'h1;
            arm <= wr ? 1'b0 : (arm || first_match_irq_out);
            if (wr) begin
                case (paddr_in)
                    8'h00: m <= pwdata_in[3:2];
                    8'h04: cc <= pwdata_in[2:0];
                    8'h08: os <= pwdata_in[5];
                    8'h0C: pm <= pwdata_in[7:0];
                    8'h14: f <= pwdata_in[15:0];
                    8'h18: s <= pwdata_in[15:0];
                    default: ;
                endcase
            end
        end
    end

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    ready_high_a: assert property (pready_out)
        else $error("pready low");
    err_access_a: assert property (pslverr_out |-> psel_in && penable_in)
        else $error("pslverr outside access");
    pg_period_a: assert property (
        arm && first_match_irq_out && m == 2'h3 && cc == 3'h0
        |-> g1 == ({8'h00, f} + 24'h1) << pm[2:0]) else $error("pulse period wrong");
    pg_clear_a: assert property (
        arm && first_match_irq_out && m == 2'h3 && cc == 3'h0
        |-> g2 == ({8'h00, f} - {8'h00, s}) << pm[2:0]) else $error("match gap wrong");
    free_gap_a: assert property (
        arm && second_match_irq_out && m == 2'h1 && cc == 3'h0 && s > f
        |-> g1 == ({8'h00, s} - {8'h00, f}) << pm[2:0]) else $error("free gap wrong");
    cap_second_a: assert property (
        $changed(trigger_input_a_in) && cc[2] && m != 2'h0 && pm[5:4] == 2'h3
        |=> second_match_irq_out) else $error("no second capture");
    cap_first_a: assert property (
        $changed(trigger_input_b_in) && cc[1:0] == 2'h3 && m != 2'h0 && pm[7:6] == 2'h3
        |=> first_match_irq_out) else $error("no first capture");
    os_end_a: assert property (
        $fell(timer_output_pin_out) && os && (m == 2'h1 || m == 2'h2)
        |-> second_match_irq_out) else $error("pulse end without match");
endmodule : t16pg_chk

bind t16pg_top t16pg_chk chk_u (.*);

`default_nettype wire

// >>> verification/t16pg_pin_model.sv
// far side: trigger sources, output pulse monitor
// assumes: bench calls its tasks; times in clocks
`timescale 1ns/1ps
`default_nettype none

module t16pg_pin_model (
    input  wire logic clk_in,     // system clock
    input  wire logic pin_in,     // timer output
    output logic      trig_a_out, // trigger input a
    output logic      trig_b_out  // trigger input b
);
    int hi_w  = 0;
    int per   = 0;
    int rises = 0;
    int run   = 0;
    int last  = 0;
    int cyc   = 0;

    // triggers move only when told
    initial begin
        trig_a_out = 1'b0;
        trig_b_out = 1'b0;
    end

    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        run <= pin_in ? run + 1 : 0;
        if (!pin_in && run != 0) begin
            hi_w <= run;
        end
        if (pin_in && run == 0) begin
            rises <= rises + 1;
            per <= cyc - last;
            last <= cyc;
        end
    end

    task automatic flip_a();
        @(posedge clk_in);
        trig_a_out <= !trig_a_out;
    endtask : flip_a

    task automatic flip_b();
        @(posedge clk_in);
        trig_b_out <= !trig_b_out;
    endtask : flip_b
endmodule : t16pg_pin_model

`default_nettype wire

// >>> verification/tb.sv
// timer bench: apb sequences, expected values
// assumes: triggers come from the pin model
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        clk_sys_in = 1'b0;
    logic        rst_b_in   = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = 8'h00;
    logic [31:0] pwdata     = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        trig_a;
    logic        trig_b;
    logic        pin;
    logic        irq1;
    logic        irq2;
    logic [31:0] qa;
    logic [31:0] qb;
    logic        e;
    int          n0;
    int          bad_count = 0;
    int          tests_run = 0;
    logic [7:0]  offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [31:0] rv   [7] = '{32'h0, 32'h0, 32'h0, 32'hA0, 32'h0, 32'h0, 32'h0};

    always #5 clk_sys_in = !clk_sys_in;

    t16pg_top dut_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .trigger_input_a_in(trig_a), .trigger_input_b_in(trig_b),
        .timer_output_pin_out(pin), .first_match_irq_out(irq1), .second_match_irq_out(irq2));
    t16pg_pin_model pm_u (.clk_in(clk_sys_in), .pin_in(pin), .trig_a_out(trig_a),
        .trig_b_out(trig_b));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    // idle edge before each setup
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        @(posedge clk_sys_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            bad_count++;
            give_verdict();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, qa, e);
    endtask : wr

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, qa, e);
        chk(nm, x, qa);
    endtask : rdc

    initial begin
        repeat (10) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        foreach (offs[i]) rdc("reset value", offs[i], rv[i]);
        apb(1'b0, 8'h1C, 32'h0, qa, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, qa);
        // software one-shot, free-running
        wr(8'h14, 32'h5);
        wr(8'h18, 32'hC);
        wr(8'h08, 32'h21);
        wr(8'h00, 32'h4);
        n0 = pm_u.rises;
        wr(8'h08, 32'h61);
        repeat (40) @(posedge clk_sys_in);
        chk("one-shot width", 32'd7, pm_u.hi_w);
        chk("one-shot count", n0 + 1, pm_u.rises);
        // stopped: no pulse
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h61);
        repeat (40) @(posedge clk_sys_in);
        chk("stopped count", n0 + 1, pm_u.rises);
        // trigger a edge, clear-on-edge mode
        wr(8'h0C, 32'hB0);
        wr(8'h00, 32'h8);
        pm_u.flip_a();
        repeat (40) @(posedge clk_sys_in);
        chk("edge width", 32'd7, pm_u.hi_w);
        chk("edge count", n0 + 2, pm_u.rises);
        // two-input width capture
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h4);
        wr(8'h04, 32'h7);
        wr(8'h0C, 32'hF0);
        pm_u.flip_a();
        repeat (19) @(posedge clk_sys_in);
        pm_u.flip_b();
        repeat (4) @(posedge clk_sys_in);
        apb(1'b0, 8'h18, 32'h0, qa, e);
        apb(1'b0, 8'h14, 32'h0, qb, e);
        chk("captured width", 32'd20, qb - qa);
        wr(8'h04, 32'h5);
        pm_u.flip_a();
        repeat (4) @(posedge clk_sys_in);
        apb(1'b0, 8'h18, 32'h0, qa, e);
        apb(1'b0, 8'h14, 32'h0, qb, e);
        chk("same capture", qa, qb);
        // pulse generator, two rates
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h0);
        for (int dv = 0; dv < 2; dv++) begin
            wr(8'h14, 32'h9);
            wr(8'h18, 32'h3);
            wr(8'h0C, 32'hA0 | dv);
            wr(8'h08, 32'h1);
            wr(8'h00, 32'hC);
            repeat (80) @(posedge clk_sys_in);
            chk("pulse period", 32'd10 << dv, pm_u.per);
            chk("pulse high", 32'd4 << dv, pm_u.hi_w);
            wr(8'h00, 32'h0);
        end
        // free run through one wrap
        wr(8'h0C, 32'hA0);
        wr(8'h14, 32'd100);
        wr(8'h18, 32'd130);
        wr(8'h00, 32'h4);
        repeat (65600) @(posedge clk_sys_in);
        rdc("overflow set", 8'h00, 32'h5);
        wr(8'h00, 32'h5);
        rdc("overflow kept", 8'h00, 32'h5);
        wr(8'h00, 32'h4);
        rdc("overflow cleared", 8'h00, 32'h4);
        give_verdict();
    end
endmodule : tb

`default_nettype wire
